//--- bcm_map.vh
`ifndef BCM_MAP_VH
`define BCM_MAP_VH
// Register byte addresses: printed offsets are not all multiples of four, so index * 4
`define BCM_IDX_CTL1 8'ha8
`define BCM_IDX_CTL2 8'ha9
`define BCM_IDX_CTL3 8'haa
`define BCM_IDX_STAT 8'hab
`define BCM_ADDR_CTL1 10'h2a0
`define BCM_ADDR_CTL2 10'h2a4
`define BCM_ADDR_CTL3 10'h2a8
`define BCM_ADDR_STAT 10'h2ac
// Control one fields
`define BCM_C1_TEMP_CHOKE 9
`define BCM_C1_USB_CHOKE 8
`define BCM_C1_RECOV_TC 7
`define BCM_C1_FAST_EN 5
`define BCM_C1_THROTTLE 4
// Control two fields
`define BCM_C2_TRICKLE_SEL 6
`define BCM_C2_ISEL_HI 3
`define BCM_C2_ISEL_LO 0
`define BCM_C2_ISEL_RESET 4'h6
// Control three fields
`define BCM_C3_FORCE 7
`define BCM_C3_TSTEP_HI 6
`define BCM_C3_TSTEP_LO 5
// Status fields
`define BCM_ST_FAST_READY_EV 0
`define BCM_ST_FAST_OK 1
`define BCM_ST_TRICKLE 2
`define BCM_ST_FAST 3
`define BCM_ST_CHOKED 4
`define BCM_ST_TERMINATED 5
// Charge modes
`define BCM_MODE_IDLE 2'h0
`define BCM_MODE_TRICKLE 2'h1
`define BCM_MODE_FAST 2'h2
// Power states
`define BCM_PWR_ACTIVE 2'h1
// Timing: clock 25 MHz, times in microseconds
`define BCM_CLK_MHZ 25
// Last count of the microsecond divider, 25 cycles per microsecond
`define BCM_US_LAST 5'h18
// Timer loads, sized to the 23-bit microsecond timer
`define BCM_SUSPEND_US 23'h7a1200
`define BCM_RECOV_FAST_US 23'h0000b4
`define BCM_RECOV_SLOW_US 23'h004e21
`define BCM_TSTEP0_US 23'h000008
`define BCM_TSTEP1_US 23'h000010
`define BCM_TSTEP2_US 23'h000020
`define BCM_TSTEP3_US 23'h000080
// Trickle currents in mA
`define BCM_TRICKLE_LO_MA 8'h32
`define BCM_TRICKLE_HI_MA 8'h64
`endif

//--- bcm_us_tick.v
`timescale 1ns/1ns
`include "bcm_map.vh"
// Microsecond enable pulse from the 25 MHz clock
module bcm_us_tick (
  input wire clk_in,
  input wire nrst_in,
  output reg tick_out
);
  reg [4:0] count;

  // Divide by the cycles in one microsecond
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= 5'h00;
      tick_out <= 1'b0;
    end else if (count == `BCM_US_LAST) begin
      count <= 5'h00;
      tick_out <= 1'b1;
    end else begin
      count <= count + 5'h01;
      tick_out <= 1'b0;
    end
  end
endmodule // bcm_us_tick

//--- bcm_us_timer.v
`timescale 1ns/1ns
`include "bcm_map.vh"
// Microsecond down-counter; done is high while loaded time has run out
module bcm_us_timer (
  input wire clk_in,
  input wire nrst_in,
  input wire tick_in,
  input wire load_in,
  input wire [22:0] load_us_in,
  output wire done_out
);
  reg [22:0] remain;

  assign done_out = (remain == 23'h000000);

  // Load wins over counting
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      remain <= 23'h000000;
    end else if (load_in) begin
      remain <= load_us_in;
    end else if (tick_in && !done_out) begin
      remain <= remain - 23'h000001;
    end
  end
endmodule // bcm_us_timer

//--- bcm_charge_ctrl.v
`timescale 1ns/1ns
`include "bcm_map.vh"
// Overview of operation
// - Trickle charging is on by default with wall or USB source selected.
// - Without force, trickle starts only when battery is 100mV under target.
// - Force bit, control three bit 7, makes trickle charging unconditional.
// - Control two bit 6 picks trickle current: 0 is 50mA, 1 is 100mA.
// - Trickle temperature choke suspends charge above 115C for 8s and until cool.
// - Trickle USB choke drops a 100mA demand to 50mA, only step.
// - Control one bit 7 picks recovery step-up: 180us or over 20ms.
// - Control one bits 9 and 8 enable temperature and USB choking.
// - Fast charge never starts alone; the host must write the enable.
// - Fast allowed only ACTIVE, wall or USB high power, good source, battery over 3.1V.
// - Ready event flag is set when fast conditions become satisfied.
// - Fast enable is held zero while conditions fail; host writes ignored.
// - Fast charge always suspends above 115C for 8s and until cool.
// - USB limit in fast charge throttles if enabled, else terminates charging.
// - With throttle enabled, end-of-charge indication is suppressed.
// - Fast charge falls back to trickle when conditions cease, or to idle if the trickle source is lost.
// - Ready event sets on rising edge and clears when read.
// - Throttle step time codes: 8us, 16us, 32us, 128us.
module bcm_charge_ctrl (
  input wire clk_in,
  input wire nrst_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  input wire wall_src_in,
  input wire usb_src_in,
  input wire usb_high_power_in,
  input wire [1:0] power_state_in,
  input wire source_ok_in,
  input wire batt_below_target_in,
  input wire batt_above_fast_min_in,
  input wire over_temp_in,
  input wire usb_limit_in,
  input wire eoc_current_in,
  output reg trickle_on_out,
  output reg fast_on_out,
  output reg [7:0] trickle_ma_out,
  output reg [3:0] fast_limit_out,
  output reg throttle_step_out,
  output reg throttle_up_out,
  output reg eoc_flag_out
);
  reg [15:0] ctl1;
  reg [15:0] ctl2;
  reg [15:0] ctl3;
  reg fast_ready_event;
  reg fast_ok_d;
  reg [1:0] mode;
  reg [1:0] next_mode;
  reg suspended;
  reg usb_choked;
  reg terminated;
  reg wr_pend;
  reg [9:0] wr_addr;
  reg timer_load;
  reg [22:0] timer_us;
  reg [22:0] tstep_us;
  reg throttle_run;
  wire us_tick;
  wire timer_done;
  wire fast_ok;
  wire trickle_ok;
  wire rd_ok;
  wire [9:0] rd_addr;
  wire [15:0] status;
  wire hazard;

  // Decodes a byte address to a register select
  function [3:0] bcm_decode;
    input [9:0] addr;
    begin
      bcm_decode = {addr == `BCM_ADDR_STAT, addr == `BCM_ADDR_CTL3,
                    addr == `BCM_ADDR_CTL2, addr == `BCM_ADDR_CTL1};
    end
  endfunction

  bcm_us_tick u_tick (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .tick_out(us_tick)
  );

  bcm_us_timer u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .tick_in(us_tick),
    .load_in(timer_load),
    .load_us_in(timer_us),
    .done_out(timer_done)
  );

  // Charge conditions
  assign fast_ok = (power_state_in == `BCM_PWR_ACTIVE) && source_ok_in &&
                   (wall_src_in || (usb_src_in && usb_high_power_in)) &&
                   batt_above_fast_min_in;
  assign trickle_ok = (wall_src_in || usb_src_in) && source_ok_in;
  assign rd_ok = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  assign rd_addr = haddr_in[9:0];
  assign status = {10'h000, terminated, suspended | usb_choked, mode == `BCM_MODE_FAST,
                   mode == `BCM_MODE_TRICKLE, fast_ok, fast_ready_event};
  // Thermal hold applies in fast always, in trickle only when enabled
  assign hazard = over_temp_in && ((mode == `BCM_MODE_FAST) ||
                  ctl1[`BCM_C1_TEMP_CHOKE]);

  // AHB-Lite slave: zero wait states, OKAY always, writes land in data phase
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend <= 1'b0;
      wr_addr <= 10'h000;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pend <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
      wr_addr <= haddr_in[9:0];
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (rd_ok) begin
        case (bcm_decode(rd_addr))
          4'h1: hrdata_out <= {16'h0000, ctl1};
          4'h2: hrdata_out <= {16'h0000, ctl2};
          4'h4: hrdata_out <= {16'h0000, ctl3};
          4'h8: hrdata_out <= {16'h0000, status};
          default: hrdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // Control registers; fast enable only writable while conditions hold
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl1 <= 16'h0000;
      ctl2 <= {12'h000, `BCM_C2_ISEL_RESET};
      ctl3 <= 16'h0000;
    end else begin
      if (wr_pend && bcm_decode(wr_addr) == 4'h1) begin
        ctl1 <= hwdata_in[15:0];
        ctl1[`BCM_C1_FAST_EN] <= hwdata_in[`BCM_C1_FAST_EN] && fast_ok;
      end
      if (!fast_ok) begin
        ctl1[`BCM_C1_FAST_EN] <= 1'b0;
      end
      if (wr_pend && bcm_decode(wr_addr) == 4'h2) begin
        ctl2 <= hwdata_in[15:0];
      end
      if (wr_pend && bcm_decode(wr_addr) == 4'h4) begin
        ctl3 <= hwdata_in[15:0];
      end
    end
  end

  // Ready event: rising edge of fast_ok sets, status read clears, set wins
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fast_ok_d <= 1'b0;
      fast_ready_event <= 1'b0;
    end else begin
      fast_ok_d <= fast_ok;
      if (fast_ok && !fast_ok_d) begin
        fast_ready_event <= 1'b1;
      end else if (rd_ok && bcm_decode(rd_addr) == 4'h8) begin
        fast_ready_event <= 1'b0;
      end
    end
  end

  // Mode selection: one machine, trickle and fast exclusive
  always @* begin
    next_mode = mode;
    case (mode)
      `BCM_MODE_IDLE: begin
        if (trickle_ok && !terminated &&
            (ctl3[`BCM_C3_FORCE] || batt_below_target_in)) begin
          next_mode = `BCM_MODE_TRICKLE;
        end
      end
      `BCM_MODE_TRICKLE: begin
        if (!trickle_ok || terminated) begin
          next_mode = `BCM_MODE_IDLE;
        end else if (ctl1[`BCM_C1_FAST_EN] && fast_ok) begin
          next_mode = `BCM_MODE_FAST;
        end
      end
      `BCM_MODE_FAST: begin
        if (terminated) begin
          next_mode = `BCM_MODE_IDLE;
        end else if (!fast_ok || !ctl1[`BCM_C1_FAST_EN]) begin
          next_mode = trickle_ok ? `BCM_MODE_TRICKLE : `BCM_MODE_IDLE;
        end
      end
      default: next_mode = `BCM_MODE_IDLE;
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode <= `BCM_MODE_IDLE;
    end else begin
      mode <= next_mode;
    end
  end

  // Throttle step interval by code
  always @* begin
    case (ctl3[`BCM_C3_TSTEP_HI:`BCM_C3_TSTEP_LO])
      2'h0: tstep_us = `BCM_TSTEP0_US;
      2'h1: tstep_us = `BCM_TSTEP1_US;
      2'h2: tstep_us = `BCM_TSTEP2_US;
      default: tstep_us = `BCM_TSTEP3_US;
    endcase
  end

  // Shared timer: thermal hold, choke recovery, throttle stepping
  always @* begin
    timer_load = 1'b0;
    timer_us = `BCM_SUSPEND_US;
    if (hazard && !suspended && mode != `BCM_MODE_IDLE) begin
      timer_load = 1'b1;
    end else if (mode == `BCM_MODE_TRICKLE && usb_limit_in && ctl1[`BCM_C1_USB_CHOKE] &&
                 ctl2[`BCM_C2_TRICKLE_SEL] && !suspended) begin
      timer_load = 1'b1;
      timer_us = ctl1[`BCM_C1_RECOV_TC] ? `BCM_RECOV_SLOW_US :
                 `BCM_RECOV_FAST_US;
    end else if (throttle_run && timer_done) begin
      timer_load = 1'b1;
      timer_us = tstep_us;
    end
  end

  // Suspend, choke, termination and throttle state
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      suspended <= 1'b0;
      usb_choked <= 1'b0;
      terminated <= 1'b0;
      throttle_run <= 1'b0;
    end else begin
      if (hazard && mode != `BCM_MODE_IDLE) begin
        suspended <= 1'b1;
      end else if (timer_done && !over_temp_in) begin
        suspended <= 1'b0;
      end
      if (mode == `BCM_MODE_TRICKLE && usb_limit_in && ctl1[`BCM_C1_USB_CHOKE] &&
          ctl2[`BCM_C2_TRICKLE_SEL]) begin
        usb_choked <= 1'b1;
      end else if (timer_done && !suspended) begin
        usb_choked <= 1'b0;
      end
      throttle_run <= mode == `BCM_MODE_FAST && usb_limit_in &&
                      ctl1[`BCM_C1_THROTTLE] && !suspended;
      if (mode == `BCM_MODE_FAST && usb_limit_in && !ctl1[`BCM_C1_THROTTLE]) begin
        terminated <= 1'b1;
      end else if (!trickle_ok || (!ctl3[`BCM_C3_FORCE] && batt_below_target_in &&
                   mode == `BCM_MODE_IDLE)) begin
        terminated <= 1'b0;
      end
    end
  end

  // Charger outputs, all registered
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trickle_on_out <= 1'b0;
      fast_on_out <= 1'b0;
      trickle_ma_out <= 8'h00;
      fast_limit_out <= 4'h0;
      throttle_step_out <= 1'b0;
      throttle_up_out <= 1'b0;
      eoc_flag_out <= 1'b0;
    end else begin
      trickle_on_out <= mode == `BCM_MODE_TRICKLE && !suspended;
      fast_on_out <= mode == `BCM_MODE_FAST && !suspended;
      trickle_ma_out <= (ctl2[`BCM_C2_TRICKLE_SEL] && !usb_choked) ?
                        `BCM_TRICKLE_HI_MA : `BCM_TRICKLE_LO_MA;
      fast_limit_out <= ctl2[`BCM_C2_ISEL_HI:`BCM_C2_ISEL_LO];
      throttle_step_out <= throttle_run && timer_done;
      throttle_up_out <= throttle_run ? 1'b0 : 1'b1;
      eoc_flag_out <= eoc_current_in && mode != `BCM_MODE_IDLE &&
                      !(mode == `BCM_MODE_FAST && ctl1[`BCM_C1_THROTTLE]) &&
                      !(mode == `BCM_MODE_TRICKLE &&
                        (ctl1[`BCM_C1_USB_CHOKE] || ctl1[`BCM_C1_TEMP_CHOKE]));
    end
  end
endmodule // bcm_charge_ctrl

//--- bcm_charge_props.sv
`timescale 1ns/1ns
`include "bcm_map.vh"
// Port-level checks on the charge mode controller
module bcm_charge_props (
  input wire clk_in,
  input wire nrst_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire hready_in,
  input wire wall_src_in,
  input wire usb_src_in,
  input wire usb_high_power_in,
  input wire [1:0] power_state_in,
  input wire source_ok_in,
  input wire batt_above_fast_min_in,
  input wire trickle_on_out,
  input wire fast_on_out,
  input wire [7:0] trickle_ma_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  reg [2:0] wr_age;
  // Cycles since the host last wrote control one, saturating
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_age <= 3'h7;
    end else if (hsel_in && hready_in && htrans_in[1] && hwrite_in &&
                 haddr_in == {22'h0, `BCM_ADDR_CTL1}) begin
      wr_age <= 3'h0;
    end else if (wr_age != 3'h7) begin
      wr_age <= wr_age + 3'h1;
    end
  end
  AST_EXCLUSIVE: assert property (!(trickle_on_out && fast_on_out))
    else $error("trickle and fast on together");
  AST_TRICKLE_MA: assert property (trickle_on_out |->
    trickle_ma_out == `BCM_TRICKLE_LO_MA || trickle_ma_out == `BCM_TRICKLE_HI_MA)
    else $error("trickle current not 50 or 100");
  AST_FAST_BY_HOST: assert property ($rose(fast_on_out) |-> wr_age <= 3'h5)
    else $error("fast charge began without a host write");
  AST_FAST_COND: assert property ($rose(fast_on_out) |->
    power_state_in == `BCM_PWR_ACTIVE && source_ok_in && batt_above_fast_min_in)
    else $error("fast charge began with conditions unmet");
  AST_BATT_LOW: assert property (!batt_above_fast_min_in |-> ##[1:3] !fast_on_out)
    else $error("fast charge kept with low battery");
  AST_NOT_ACTIVE: assert property (
    power_state_in != `BCM_PWR_ACTIVE |-> ##[1:3] !fast_on_out)
    else $error("fast charge kept outside active state");
  AST_USB_LOW: assert property (
    usb_src_in && !wall_src_in && !usb_high_power_in |-> ##[1:3] !fast_on_out)
    else $error("fast charge kept in usb low power");
  AST_SRC_BAD: assert property (!source_ok_in |-> ##[1:3] !fast_on_out)
    else $error("fast charge kept with bad source");
  AST_NO_SOURCE: assert property (
    !wall_src_in && !usb_src_in |-> ##[1:3] !trickle_on_out)
    else $error("trickle kept with no source");
  // Main scenarios reached
  cover property ($rose(fast_on_out));
  cover property (trickle_on_out && trickle_ma_out == `BCM_TRICKLE_HI_MA);
  cover property ($fell(fast_on_out) ##[1:3] trickle_on_out);
endmodule // bcm_charge_props

bind bcm_charge_ctrl bcm_charge_props u_props (.clk_in, .nrst_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hready_in, .wall_src_in, .usb_src_in, .usb_high_power_in,
  .power_state_in, .source_ok_in, .batt_above_fast_min_in, .trickle_on_out,
  .fast_on_out, .trickle_ma_out);

//--- bcm_host_model.sv
`timescale 1ns/1ns
// AHB-Lite master standing in for the host processor
module bcm_host_model (
  input wire clk_in,
  input wire hready_in,
  input wire [31:0] hrdata_in,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [31:0] hwdata_out
);
  int tmo_count = 0;
  // Bus idle at time zero
  initial begin
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hwdata_out = 32'h0;
  end
  // Ends at the rising edge where hready is high, bounded
  task automatic wait_rdy(output logic [31:0] rd);
    int n;
    logic r;
    n = 0;
    r = 1'b0;
    while (r !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      r = hready_in;
      rd = hrdata_in;
      n++;
    end
    if (r !== 1'b1) tmo_count++;
  endtask
  // Single word transfer; fast charge only ever by host request
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic [31:0] x;
    @(posedge clk_in);
    haddr_out <= a;
    htrans_out <= 2'h2;
    hwrite_out <= w;
    wait_rdy(x);
    htrans_out <= 2'h0;
    hwdata_out <= wd;
    wait_rdy(rd);
  endtask
endmodule // bcm_host_model

//--- bcm_tb.sv
`timescale 1ns/1ns
`include "bcm_map.vh"
// Self-checking bench for the charge mode controller
module tb;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wall = 1'b0;
  logic usb = 1'b0;
  logic usb_hp = 1'b0;
  logic [1:0] pwr = `BCM_PWR_ACTIVE;
  logic src_ok = 1'b1;
  logic below = 1'b0;
  logic above = 1'b0;
  logic hot = 1'b0;
  logic lim = 1'b0;
  logic eoc = 1'b0;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire hwrite, hready, hresp, trk_on, fast_on, step, eoc_flag, thr_up;
  wire [7:0] trk_ma;
  wire [3:0] flim;
  logic [31:0] d;
  int err_count = 0;
  int check_count = 0;
  int ts[4] = '{8, 16, 32, 128};
  localparam logic [31:0] a_c1 = `BCM_ADDR_CTL1;
  localparam logic [31:0] a_c2 = `BCM_ADDR_CTL2;
  localparam logic [31:0] a_c3 = `BCM_ADDR_CTL3;
  localparam logic [31:0] a_st = `BCM_ADDR_STAT;
  always #20 clk_in = ~clk_in;
  bcm_charge_ctrl DUT (.clk_in, .nrst_in, .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .wall_src_in(wall), .usb_src_in(usb), .usb_high_power_in(usb_hp),
    .power_state_in(pwr), .source_ok_in(src_ok), .batt_below_target_in(below),
    .batt_above_fast_min_in(above), .over_temp_in(hot), .usb_limit_in(lim),
    .eoc_current_in(eoc), .trickle_on_out(trk_on), .fast_on_out(fast_on),
    .trickle_ma_out(trk_ma), .fast_limit_out(flim), .throttle_step_out(step),
    .throttle_up_out(thr_up), .eoc_flag_out(eoc_flag));
  bcm_host_model host (.clk_in, .hready_in(hready), .hrdata_in(hrdata),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] x;
    host.xfer(a, 1'b1, v, x);
    if (host.tmo_count != 0) wrap_up;
  endtask
  task automatic rd(input logic [31:0] a);
    host.xfer(a, 1'b0, 32'h0, d);
    if (host.tmo_count != 0) wrap_up;
  endtask
  task automatic settle;
    repeat (6) @(posedge clk_in);
  endtask
  task automatic do_reset;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
  endtask
  // Cycles between two throttle step pulses
  task automatic gap(output int n);
    int k;
    k = 0;
    do begin @(negedge clk_in); k++; end while (step !== 1'b1 && k < 9000);
    n = 0;
    do begin @(negedge clk_in); n++; end while (step !== 1'b1 && n < 9000);
  endtask
  task automatic t_regs;
    rd(a_c1);
    chk("ctl1 reset", 32'h0, d);
    rd(a_c2);
    chk("ctl2 reset", 32'h6, d);
    rd(a_c3);
    chk("ctl3 reset", 32'h0, d);
    chk("limit out", 32'h6, flim);
    wr(a_c1, 32'h390);
    rd(a_c1);
    chk("ctl1 rw", 32'h390, d);
    wr(a_c1, 32'h0);
    wr(32'h3fc, 32'hffff);
    rd(32'h3fc);
    chk("unmapped", 32'h0, d);
    chk("hresp", 32'h0, hresp);
    chk("hready", 32'h1, hready);
  endtask
  task automatic t_trickle;
    wall <= 1'b1;
    settle;
    chk("no start", 32'h0, trk_on);
    wr(a_c3, 32'h80);
    settle;
    chk("forced", 32'h1, trk_on);
    below <= 1'b1;
    settle;
    chk("trickle 50", 32'h32, trk_ma);
    wr(a_c2, 32'h46);
    settle;
    chk("trickle 100", 32'h64, trk_ma);
  endtask
  task automatic t_choke;
    int n;
    wall <= 1'b0;
    usb <= 1'b1;
    lim <= 1'b1;
    settle;
    chk("no choke", 32'h64, trk_ma);
    wr(a_c1, 32'h100);
    settle;
    chk("usb choke", 32'h32, trk_ma);
    lim <= 1'b0;
    n = 0;
    do begin @(negedge clk_in); n++; end while (trk_ma !== 8'h64 && n < 9000);
    chk("recovery", 32'h1, n > 4400 && n < 4600);
    settle;
    hot <= 1'b1;
    settle;
    chk("hot no choke", 32'h1, trk_on);
    wr(a_c1, 32'h200);
    settle;
    chk("hot choke", 32'h0, trk_on);
    hot <= 1'b0;
    settle;
    chk("hold 8s", 32'h0, trk_on);
  endtask
  task automatic t_fast;
    int k;
    usb <= 1'b0;
    wall <= 1'b1;
    wr(a_c1, 32'h20);
    rd(a_c1);
    chk("fast en held", 32'h0, d);
    chk("fast off", 32'h0, fast_on);
    rd(a_st);
    above <= 1'b1;
    settle;
    rd(a_st);
    chk("ready event", 32'h3, d & 32'h3);
    rd(a_st);
    chk("event cleared", 32'h2, d & 32'h3);
    for (k = 0; k < 4; k++) begin
      wr(a_c1, 32'h20);
      settle;
      chk("fast on", 32'h1, fast_on);
      chk("trickle off", 32'h0, trk_on);
      case (k)
        0: above <= 1'b0;
        1: pwr <= 2'h0;
        2: usb <= 1'b1;
        default: src_ok <= 1'b0;
      endcase
      if (k == 2) wall <= 1'b0;
      settle;
      chk("fast dropped", 32'h0, fast_on);
      if (k < 3) chk("to trickle", 32'h1, trk_on);
      wall <= 1'b1;
      usb <= 1'b0;
      pwr <= `BCM_PWR_ACTIVE;
      src_ok <= 1'b1;
      above <= 1'b1;
      settle;
    end
  endtask
  task automatic t_throttle;
    int n;
    int k;
    wall <= 1'b0;
    usb <= 1'b1;
    usb_hp <= 1'b1;
    eoc <= 1'b1;
    settle;
    chk("eoc shown", 32'h1, eoc_flag);
    wr(a_c1, 32'h30);
    settle;
    lim <= 1'b1;
    eoc <= 1'b1;
    settle;
    chk("throttled", 32'h1, fast_on);
    chk("eoc hidden", 32'h0, eoc_flag);
    chk("throttle up", 32'h0, thr_up);
    for (k = 0; k < 4; k++) begin
      wr(a_c3, 32'(k << 5));
      gap(n);
      gap(n);
      chk("step gap", ts[k] * 25, n);
    end
    wr(a_c1, 32'h20);
    // Battery near target so the latched termination is not released
    below <= 1'b0;
    settle;
    chk("terminated", 32'h0, fast_on);
    chk("no trickle after term", 32'h0, trk_on);
    chk("throttle released", 32'h1, thr_up);
    rd(a_st);
    chk("term flag", 32'h20, d & 32'h20);
  endtask
  task automatic wrap_up;
    err_count += host.tmo_count;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence, with a second reset before fast charging
  initial begin
    do_reset;
    t_regs;
    t_trickle;
    t_choke;
    do_reset;
    t_fast;
    t_throttle;
    wrap_up;
  end
endmodule // tb
